// ---- src/gcb_pkg.sv ----
package gcb_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam int CFG_W = 8;
  localparam int PIN_W = 4;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_1_7 = 6'h2a;
  localparam logic [IDX_W-1:0] IDX_2_0 = 6'h2b;
  localparam logic [IDX_W-1:0] IDX_2_1 = 6'h2c;
  localparam logic [IDX_W-1:0] IDX_2_2 = 6'h2d;
  localparam logic [IDX_W-1:0] IDX_UNUSED = 6'h2e;
  localparam logic [IDX_W-1:0] IDX_2_4 = 6'h2f;
  localparam logic [IDX_W-1:0] IDX_2_5 = 6'h30;
  localparam logic [IDX_W-1:0] IDX_2_6 = 6'h31;
  localparam logic [IDX_W-1:0] IDX_2_7 = 6'h32;
  localparam logic [IDX_W-1:0] IDX_3_0 = 6'h33;
  localparam logic [IDX_W-1:0] IDX_3_1 = 6'h34;

  // Pin positions in every per-pin vector, in register order.
  localparam int P_1_7 = 0;
  localparam int P_2_0 = 1;
  localparam int P_2_1 = 2;
  localparam int P_2_2 = 3;
  localparam int P_2_4 = 4;
  localparam int P_2_5 = 5;
  localparam int P_2_6 = 6;
  localparam int P_2_7 = 7;
  localparam int P_3_0 = 8;
  localparam int P_3_1 = 9;

  // Register index of each pin position.
  localparam logic [IDX_W-1:0] PIN_IDX [NUM_PINS] = '{
    IDX_1_7, IDX_2_0, IDX_2_1, IDX_2_2, IDX_2_4,
    IDX_2_5, IDX_2_6, IDX_2_7, IDX_3_0, IDX_3_1
  };

  // ----------------------------------------------------------------
  // Field layout and values
  // ----------------------------------------------------------------
  localparam int BIT_DIR = 0;
  localparam int BIT_POL = 1;
  localparam int BIT_ALT = 2;
  localparam int FN_LO = 2;
  localparam int FN_HI = 3;
  localparam int BIT_OD = 7;
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_KBC = 2'h1;
  localparam logic [1:0] FN_EDGE = 2'h2;
  localparam logic [1:0] FN_FLOPPY = 2'h3;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h01;
  localparam logic ALT_IDLE = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } gcb_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } gcb_axi_rsp_t;

  // Signals that peripherals hand to the pins.
  typedef struct packed {
    logic kbc_port_bit7;
    logic kbc_port_bit6;
    logic kbc_port_bit2;
    logic floppy_drive_select_one_n;
    logic floppy_motor_one_n;
    logic music_serial_tx;
    logic sys_mgmt_irq_out_n;
  } gcb_alt_in_t;

  // Signals that the pins hand to peripherals.
  typedef struct packed {
    logic joystick_two_y_axis;
    logic kbc_port_bit7;
    logic kbc_port_bit6;
    logic kbc_port_bit2;
    logic music_serial_rx;
    logic fan_speed_sense_one;
    logic fan_speed_sense_two;
    logic [1:0] edge_irq;
  } gcb_alt_out_t;

  typedef enum logic [0:0] {WR_IDLE, WR_RESP} gcb_wr_st_t;
  typedef enum logic [0:0] {RD_IDLE, RD_RESP} gcb_rd_st_t;

  typedef struct packed {
    logic [NUM_PINS-1:0][CFG_W-1:0] cfg;
    gcb_wr_st_t wr_st;
    gcb_rd_st_t rd_st;
    logic aw_got;
    logic w_got;
    logic [IDX_W-1:0] aw_idx;
    logic [CFG_W-1:0] w_data;
    logic w_lane0;
    logic [1:0] bresp;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [NUM_PINS-1:0] pad_out;
    logic [NUM_PINS-1:0] pad_oe;
    logic [NUM_PINS-1:0] gpio_in;
    logic [1:0] edge_prev;
    gcb_alt_out_t alt;
  } gcb_state_t;

endpackage : gcb_pkg

// ---- src/gcb_pin_cfg_bank.sv ----
// Notes on behaviour
// - Bit 0 one means input, zero output.
// - Bit 1 inverts value between register and pad.
// - Bit 7 one open drain, zero push-pull.
// - Every pin register resets to 0x01.
// - Pin 1.7 bit 2 feeds joystick Y axis.
// - Pin 2.0 bit 2 joins keyboard port bit 7.
// - Pin 2.1 field: drive select, edge, kbc6, io.
// - Pin 2.2 field: motor, edge, kbc2, io.
// - Edge interrupt fires on both pin edges.
// - Bits 6:4 of field pins do nothing.
// - Slot 2E has no function, reads zero.
// - Pin 2.4 has no alternate function.
// - Pin 2.5 bit 2 feeds music receive.
// - Pin 2.6 bit 2 drives music transmit.
// - Pin 2.7 bit 2 carries management interrupt.
// - Pins 3.0, 3.1 feed fan sense two, one.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps

module gcb_pin_cfg_bank (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire gcb_pkg::gcb_axi_req_t axi_req_i,
  output gcb_pkg::gcb_axi_rsp_t axi_rsp_o,
  input wire logic [gcb_pkg::NUM_PINS-1:0] pad_in_i,
  output logic [gcb_pkg::NUM_PINS-1:0] pad_out_o,
  output logic [gcb_pkg::NUM_PINS-1:0] pad_oe_o,
  input wire logic [gcb_pkg::NUM_PINS-1:0] gpio_out_i,
  output logic [gcb_pkg::NUM_PINS-1:0] gpio_in_o,
  input wire gcb_pkg::gcb_alt_in_t alt_i,
  output gcb_pkg::gcb_alt_out_t alt_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  gcb_pkg::gcb_state_t q; // Everything that is registered.
  gcb_pkg::gcb_state_t d; // Next value of the whole state.
  // One record keeps reset in step.

  // ----------------------------------------------------------------
  // Decode helper
  // ----------------------------------------------------------------
  // Returns the pin position of a register index with a hit flag
  // on top. A loop keeps the map in one place, the package table.
  function automatic logic [gcb_pkg::PIN_W:0] find_pin(
    input logic [gcb_pkg::IDX_W-1:0] idx
  );
    logic [gcb_pkg::PIN_W:0] res;
    res = '0;
    // Indices are unique; one hit at most.
    for (int i = 0; i < gcb_pkg::NUM_PINS; i++) begin
      if (idx == gcb_pkg::PIN_IDX[i]) begin
        res = {1'b1, i[gcb_pkg::PIN_W-1:0]};
      end
    end

    return res;
  endfunction : find_pin

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One process computes bus slave, register file and pad muxing.
  // The pad side lags its configuration by one clock, since every
  // pad output is a flip-flop.
  always_comb begin
    logic [gcb_pkg::PIN_W:0] hit;
    logic [gcb_pkg::NUM_PINS-1:0] drv;
    logic [gcb_pkg::NUM_PINS-1:0] pin_in;
    logic [1:0] fn_21;
    logic [1:0] fn_22;
    logic val;
    logic od;
    hit = '0;
    drv = '0;
    pin_in = '0;
    fn_21 = '0;
    fn_22 = '0;
    val = 1'b0;
    od = 1'b0;
    d = q;
    // Fields hold unless moved below.

    // --------------------------------------------------------------
    // Write channels
    // --------------------------------------------------------------
    // Address and data are taken in either order and held until
    // both are present; nothing more is taken while a response
    // waits, which keeps one write in flight.
    if (q.wr_st == gcb_pkg::WR_IDLE) begin
      // Address half.
      if (axi_req_i.awvalid && !q.aw_got) begin
        d.aw_got = 1'b1;
        d.aw_idx = axi_req_i.awaddr[gcb_pkg::ADDR_W-1:2];
      end

      // Data half; only lane 0 counts.
      if (axi_req_i.wvalid && !q.w_got) begin
        d.w_got = 1'b1;
        d.w_data = axi_req_i.wdata[gcb_pkg::CFG_W-1:0];
        d.w_lane0 = axi_req_i.wstrb[0];
      end
    end

    // Both halves present: perform the write and answer.
    if (d.aw_got && d.w_got) begin
      // The index may be from a past cycle.
      hit = find_pin(d.aw_idx);
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.wr_st = gcb_pkg::WR_RESP;
      d.bresp = gcb_pkg::RESP_OKAY;

      // A mapped index is written.
      if (hit[gcb_pkg::PIN_W]) begin
        // Only lane 0 holds register bits; upper lanes are dropped.
        if (d.w_lane0) begin
          d.cfg[hit[gcb_pkg::PIN_W-1:0]] = d.w_data;
        end
      end else if (d.aw_idx == gcb_pkg::IDX_UNUSED) begin
        // The empty slot accepts and discards writes.
        d.bresp = gcb_pkg::RESP_OKAY;
      end else begin
        // Unmapped: refuse, keep state.
        d.bresp = gcb_pkg::RESP_SLVERR;
      end
    end

    // Response leaves when the master takes it.
    // Its code holds until then.
    if (q.wr_st == gcb_pkg::WR_RESP && axi_req_i.bready) begin
      d.wr_st = gcb_pkg::WR_IDLE;
    end

    // --------------------------------------------------------------
    // Read channels
    // --------------------------------------------------------------
    // A read is answered on the clock after its address is taken.
    // It stands until rready.
    // One read is held at a time.
    if (q.rd_st == gcb_pkg::RD_IDLE) begin
      if (axi_req_i.arvalid) begin
        hit = find_pin(axi_req_i.araddr[gcb_pkg::ADDR_W-1:2]);
        d.rd_st = gcb_pkg::RD_RESP;
        d.rdata = '0;
        d.rresp = gcb_pkg::RESP_OKAY;
        if (hit[gcb_pkg::PIN_W]) begin
          // Reserved bits read back as written; they steer nothing.
          d.rdata[gcb_pkg::CFG_W-1:0] =
            q.cfg[hit[gcb_pkg::PIN_W-1:0]];
        end else if (axi_req_i.araddr[gcb_pkg::ADDR_W-1:2] ==
                     gcb_pkg::IDX_UNUSED) begin
          d.rdata = '0;
        end else begin
          // Unmapped: refuse, zero data.
          d.rresp = gcb_pkg::RESP_SLVERR;
        end
      end
    end else if (axi_req_i.rready) begin
      // Answer taken; reopen.
      d.rd_st = gcb_pkg::RD_IDLE;
    end

    // --------------------------------------------------------------
    // Pin inputs
    // --------------------------------------------------------------
    // The polarity bit also applies on the way in, so software and
    // alternate functions both see the corrected level.
    // Pads count as synchronous.
    for (int p = 0; p < gcb_pkg::NUM_PINS; p++) begin
      pin_in[p] = pad_in_i[p] ^ q.cfg[p][gcb_pkg::BIT_POL];
      d.gpio_in[p] = pin_in[p];
    end

    // Only bits 3:2 form the field; bits 6:4 are never looked at.
    // Reserved bits steer nothing.
    fn_21 =
      q.cfg[gcb_pkg::P_2_1][gcb_pkg::FN_HI:gcb_pkg::FN_LO];
    fn_22 =
      q.cfg[gcb_pkg::P_2_2][gcb_pkg::FN_HI:gcb_pkg::FN_LO];

    // --------------------------------------------------------------
    // Alternate inputs to peripherals
    // --------------------------------------------------------------
    // A peripheral whose pin is not routed sees the idle high level,
    // which is the quiet state of its serial or port input.
    d.alt.joystick_two_y_axis = gcb_pkg::ALT_IDLE;
    d.alt.kbc_port_bit7 = gcb_pkg::ALT_IDLE;
    d.alt.kbc_port_bit6 = gcb_pkg::ALT_IDLE;
    d.alt.kbc_port_bit2 = gcb_pkg::ALT_IDLE;
    d.alt.music_serial_rx = gcb_pkg::ALT_IDLE;
    d.alt.fan_speed_sense_one = gcb_pkg::ALT_IDLE;
    d.alt.fan_speed_sense_two = gcb_pkg::ALT_IDLE;

    // Pin 1.7: joystick timing.
    if (q.cfg[gcb_pkg::P_1_7][gcb_pkg::BIT_ALT]) begin
      d.alt.joystick_two_y_axis = pin_in[gcb_pkg::P_1_7];
    end

    // Pin 2.0: keyboard bit 7.
    if (q.cfg[gcb_pkg::P_2_0][gcb_pkg::BIT_ALT]) begin
      d.alt.kbc_port_bit7 = pin_in[gcb_pkg::P_2_0];
    end

    // Pin 2.1: keyboard bit 6.
    if (fn_21 == gcb_pkg::FN_KBC) begin
      d.alt.kbc_port_bit6 = pin_in[gcb_pkg::P_2_1];
    end

    // Pin 2.2: keyboard bit 2.
    if (fn_22 == gcb_pkg::FN_KBC) begin
      d.alt.kbc_port_bit2 = pin_in[gcb_pkg::P_2_2];
    end

    // Pin 2.5: music receive.
    if (q.cfg[gcb_pkg::P_2_5][gcb_pkg::BIT_ALT]) begin
      d.alt.music_serial_rx = pin_in[gcb_pkg::P_2_5];
    end

    // Pin 3.0: second fan sense.
    if (q.cfg[gcb_pkg::P_3_0][gcb_pkg::BIT_ALT]) begin
      d.alt.fan_speed_sense_two = pin_in[gcb_pkg::P_3_0];
    end

    // Pin 3.1: first fan sense.
    if (q.cfg[gcb_pkg::P_3_1][gcb_pkg::BIT_ALT]) begin
      d.alt.fan_speed_sense_one = pin_in[gcb_pkg::P_3_1];
    end

    // --------------------------------------------------------------
    // Edge interrupts
    // --------------------------------------------------------------
    // Any change of level against the last sample is an edge, so
    // both directions fire. The last sample is tracked even while
    // the function is off, so turning it on raises no false pulse.
    d.edge_prev[0] = pin_in[gcb_pkg::P_2_1];
    d.edge_prev[1] = pin_in[gcb_pkg::P_2_2];

    // A pulse lasts one clock.
    d.alt.edge_irq[0] = (fn_21 == gcb_pkg::FN_EDGE) &&
      (pin_in[gcb_pkg::P_2_1] != q.edge_prev[0]);
    // Same detector for pin 2.2.
    d.alt.edge_irq[1] = (fn_22 == gcb_pkg::FN_EDGE) &&
      (pin_in[gcb_pkg::P_2_2] != q.edge_prev[1]);

    // --------------------------------------------------------------
    // Output sources
    // --------------------------------------------------------------
    // Plain I/O drives the data register value; an alternate output
    // replaces it. Pins 1.7, 2.4, 2.5, 3.0 and 3.1 have no output
    // function, so only bit 2 or the field is ever consulted and
    // bits 6:4 never reach the mux.
    drv = gpio_out_i;

    // Pin 2.0: keyboard bit 7.
    if (q.cfg[gcb_pkg::P_2_0][gcb_pkg::BIT_ALT]) begin
      drv[gcb_pkg::P_2_0] = alt_i.kbc_port_bit7;
    end

    // Pin 2.1: select or bit 6.
    case (fn_21)
      gcb_pkg::FN_FLOPPY: begin
        // Active low, passed as is.
        drv[gcb_pkg::P_2_1] = alt_i.floppy_drive_select_one_n;
      end
      gcb_pkg::FN_KBC: begin
        // Keyboard port drives.
        drv[gcb_pkg::P_2_1] = alt_i.kbc_port_bit6;
      end
      default: begin
        // Plain I/O or edge input: the data register still drives.
        drv[gcb_pkg::P_2_1] = gpio_out_i[gcb_pkg::P_2_1];
      end
    endcase

    // Pin 2.2: motor or bit 2.
    case (fn_22)
      gcb_pkg::FN_FLOPPY: begin
        // Active low, passed as is.
        drv[gcb_pkg::P_2_2] = alt_i.floppy_motor_one_n;
      end
      gcb_pkg::FN_KBC: begin
        // Keyboard port drives.
        drv[gcb_pkg::P_2_2] = alt_i.kbc_port_bit2;
      end
      default: begin
        // Plain I/O or edge input.
        drv[gcb_pkg::P_2_2] = gpio_out_i[gcb_pkg::P_2_2];
      end
    endcase

    // Pin 2.6: music transmit.
    if (q.cfg[gcb_pkg::P_2_6][gcb_pkg::BIT_ALT]) begin
      drv[gcb_pkg::P_2_6] = alt_i.music_serial_tx;
    end

    // Pin 2.7: management interrupt.
    if (q.cfg[gcb_pkg::P_2_7][gcb_pkg::BIT_ALT]) begin
      drv[gcb_pkg::P_2_7] = alt_i.sys_mgmt_irq_out_n;
    end

    // --------------------------------------------------------------
    // Pad drivers
    // --------------------------------------------------------------
    // Direction gates the driver for every function; software must
    // clear bit 0 to let an alternate output reach the pad. Open
    // drain pulls low only, and releases the pad for a one.
    // Pad flops add one clock of lag.
    for (int p = 0; p < gcb_pkg::NUM_PINS; p++) begin
      // Polarity covers every source.
      val = drv[p] ^ q.cfg[p][gcb_pkg::BIT_POL];
      // Open drain drops the high side.
      od = q.cfg[p][gcb_pkg::BIT_OD];
      d.pad_out[p] = od ? 1'b0 : val;
      // An input never drives.
      d.pad_oe[p] = !q.cfg[p][gcb_pkg::BIT_DIR] &&
        (!od || !val);
    end

    // --------------------------------------------------------------
    // Reset
    // --------------------------------------------------------------
    // Reset sits last so that it overrides every update above.
    if (!nrst_i) begin
      // Clear all, then set non-zeros.
      d = '0;
      for (int p = 0; p < gcb_pkg::NUM_PINS; p++) begin
        d.cfg[p] = gcb_pkg::CFG_RESET;
      end
      // Unrouted inputs rest high.
      d.alt.joystick_two_y_axis = gcb_pkg::ALT_IDLE;
      d.alt.kbc_port_bit7 = gcb_pkg::ALT_IDLE;
      d.alt.kbc_port_bit6 = gcb_pkg::ALT_IDLE;
      d.alt.kbc_port_bit2 = gcb_pkg::ALT_IDLE;
      d.alt.music_serial_rx = gcb_pkg::ALT_IDLE;
      d.alt.fan_speed_sense_one = gcb_pkg::ALT_IDLE;
      d.alt.fan_speed_sense_two = gcb_pkg::ALT_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset is synchronous and folded into the next-state logic.
  // No enable: flops move every clock.
  always_ff @(posedge mclk_i) begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Readies are combinational from state; data come from flops.
  always_comb begin
    // Bus side.
    axi_rsp_o.awready = (q.wr_st == gcb_pkg::WR_IDLE) && !q.aw_got;
    axi_rsp_o.wready = (q.wr_st == gcb_pkg::WR_IDLE) && !q.w_got;
    axi_rsp_o.bvalid = (q.wr_st == gcb_pkg::WR_RESP);
    axi_rsp_o.bresp = q.bresp;
    axi_rsp_o.arready = (q.rd_st == gcb_pkg::RD_IDLE);
    axi_rsp_o.rvalid = (q.rd_st == gcb_pkg::RD_RESP);
    axi_rsp_o.rdata = q.rdata;
    axi_rsp_o.rresp = q.rresp;

    // Pin side.
    pad_out_o = q.pad_out;
    pad_oe_o = q.pad_oe;
    gpio_in_o = q.gpio_in;
    alt_o = q.alt;
  end

endmodule : gcb_pin_cfg_bank

// ---- testbench/gcb_pin_cfg_bank_monitor.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port-level checker for the pin configuration bank.
// ----------------------------------------------------------------
module gcb_pin_cfg_bank_monitor (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire gcb_pkg::gcb_axi_req_t axi_req_i,
  input wire gcb_pkg::gcb_axi_rsp_t axi_rsp_o,
  input wire logic [gcb_pkg::NUM_PINS-1:0] pad_in_i,
  input wire logic [gcb_pkg::NUM_PINS-1:0] pad_out_o,
  input wire logic [gcb_pkg::NUM_PINS-1:0] pad_oe_o,
  input wire logic [gcb_pkg::NUM_PINS-1:0] gpio_out_i,
  input wire logic [gcb_pkg::NUM_PINS-1:0] gpio_in_o,
  input wire gcb_pkg::gcb_alt_in_t alt_i,
  input wire gcb_pkg::gcb_alt_out_t alt_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // Register index of a read; the two low address bits are ignored.
  logic [5:0] ar_idx;
  logic ar_hit;
  logic wr_hit;
  assign ar_idx = axi_req_i.araddr[7:2];
  assign ar_hit = axi_req_i.arvalid && axi_rsp_o.arready;
  assign wr_hit = axi_req_i.awvalid && axi_rsp_o.awready &&
                  axi_req_i.wvalid && axi_rsp_o.wready;

  property p_rd_lat;
    ar_hit |=> axi_rsp_o.rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer not one cycle after address");
  property p_wr_lat;
    wr_hit |=> axi_rsp_o.bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write answer not one cycle after request");
  property p_aw_block;
    axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write channels open while answer pending");
  property p_ar_block;
    axi_rsp_o.rvalid |-> !axi_rsp_o.arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read address open while answer pending");
  property p_b_done;
    axi_rsp_o.bvalid && axi_req_i.bready |=> !axi_rsp_o.bvalid;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write answer outlived its handshake");
  property p_slot;
    ar_hit && ar_idx == gcb_pkg::IDX_UNUSED |=> axi_rsp_o.rdata == 0 &&
      axi_rsp_o.rresp == gcb_pkg::RESP_OKAY;
  endproperty
  a_slot: assert property (p_slot)
    else $error("empty slot read not zero");
  // Anything outside the bank's window is refused with zero data.
  property p_unmapped;
    ar_hit && (ar_idx < gcb_pkg::IDX_1_7 || ar_idx > gcb_pkg::IDX_3_1)
      |=> axi_rsp_o.rresp == gcb_pkg::RESP_SLVERR && axi_rsp_o.rdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  // A pulse must follow a real pad change one or two samples back.
  property p_edge0;
    alt_o.edge_irq[0] |-> $past(pad_in_i[2], 1) != $past(pad_in_i[2], 2)
      || $past(pad_in_i[2], 2) != $past(pad_in_i[2], 3);
  endproperty
  a_edge0: assert property (p_edge0)
    else $error("edge pulse zero without pad change");
  property p_edge1;
    alt_o.edge_irq[1] |-> $past(pad_in_i[3], 1) != $past(pad_in_i[3], 2)
      || $past(pad_in_i[3], 2) != $past(pad_in_i[3], 3);
  endproperty
  a_edge1: assert property (p_edge1)
    else $error("edge pulse one without pad change");

  c_read: cover property (ar_hit);
  c_write: cover property (axi_rsp_o.bvalid && axi_req_i.bready);
  c_edge: cover property (alt_o.edge_irq[0]);
endmodule : gcb_pin_cfg_bank_monitor

bind gcb_pin_cfg_bank gcb_pin_cfg_bank_monitor u_mon (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .axi_req_i(axi_req_i),
  .axi_rsp_o(axi_rsp_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
  .pad_oe_o(pad_oe_o), .gpio_out_i(gpio_out_i), .gpio_in_o(gpio_in_o),
  .alt_i(alt_i), .alt_o(alt_o)
);

// ---- testbench/gcb_pad_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Board-side pads: the bank's driver wins, then an outside driver.
// ----------------------------------------------------------------
module gcb_pad_model (
  input wire logic [9:0] pad_out_i,
  input wire logic [9:0] pad_oe_i,
  input wire logic [9:0] ext_en_i,
  input wire logic [9:0] ext_val_i,
  output logic [9:0] pad_o
);
  // An undriven pad floats to its pull-up, so open drain reads high.
  assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
               | (~pad_oe_i & ~ext_en_i);
endmodule : gcb_pad_model

// ---- testbench/gcb_pin_cfg_bank_tb.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Register-driven bench for the pin configuration bank.
// ----------------------------------------------------------------
module gcb_pin_cfg_bank_tb;
  logic mclk_i;
  logic nrst_i;
  gcb_pkg::gcb_axi_req_t req;
  gcb_pkg::gcb_axi_rsp_t rsp;
  logic [9:0] pad_in, pad_out, pad_oe, gpio_out, gpio_in, ext_en, ext_val;
  gcb_pkg::gcb_alt_in_t alt_in;
  gcb_pkg::gcb_alt_out_t alt_out;
  int err_count;
  int total_checks;
  int n;
  logic [31:0] rd;
  logic [1:0] resp;

  gcb_pin_cfg_bank uut (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .axi_req_i(req), .axi_rsp_o(rsp), .pad_in_i(pad_in),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .gpio_out_i(gpio_out),
    .gpio_in_o(gpio_in), .alt_i(alt_in), .alt_o(alt_out));
  gcb_pad_model u_pads (.pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad_in));

  // 25 MHz clock.
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h00_0000, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge mclk_i);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rdr

  // Pads follow a new setting one cycle late; three cycles is ample.
  task automatic pad(input int p, input logic oe, input logic o);
    repeat (3) @(posedge mclk_i);
    check("pad_oe", {31'h0, pad_oe[p]}, {31'h0, oe});
    if (oe) check("pad_out", {31'h0, pad_out[p]}, {31'h0, o});
  endtask : pad

  function automatic logic alt_of(input int p);
    case (p)
      0: return alt_out.joystick_two_y_axis;
      1: return alt_out.kbc_port_bit7;
      5: return alt_out.music_serial_rx;
      8: return alt_out.fan_speed_sense_two;
      default: return alt_out.fan_speed_sense_one;
    endcase
  endfunction : alt_of

  function automatic logic [7:0] ad(input int p);
    return {gcb_pkg::PIN_IDX[p], 2'b00};
  endfunction : ad

  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    close_out();
  end

  initial begin
    req = '0;
    gpio_out = '0;
    alt_in = '1;
    ext_en = '0;
    ext_val = '0;
    nrst_i = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    // Reset values, the empty slot and an unmapped address.
    for (int i = 0; i < gcb_pkg::NUM_PINS; i++) begin
      rdr(ad(i));
      check("reset_value", rd, 32'h0000_0001);
    end
    wr({gcb_pkg::IDX_UNUSED, 2'b00}, 8'hff);
    rdr({gcb_pkg::IDX_UNUSED, 2'b00});
    check("empty_slot", rd, 32'h0000_0000);
    wr(8'h04, 8'h55);
    check("unmapped_wr", {30'h0, resp}, {30'h0, gcb_pkg::RESP_SLVERR});
    rdr(8'h04);
    check("unmapped_rd", {30'h0, resp}, {30'h0, gcb_pkg::RESP_SLVERR});
    // Pin 2.4: direction, polarity, driver type and reserved bits.
    gpio_out[4] <= 1'b1;
    wr(ad(4), 8'h00);
    pad(4, 1'b1, 1'b1);
    wr(ad(4), 8'h02);
    pad(4, 1'b1, 1'b0);
    wr(ad(4), 8'h80);
    pad(4, 1'b0, 1'b0);
    gpio_out[4] <= 1'b0;
    pad(4, 1'b1, 1'b0);
    gpio_out[4] <= 1'b1;
    wr(ad(4), 8'h7c);
    pad(4, 1'b1, 1'b1);
    rdr(ad(4));
    check("readback", rd, 32'h0000_007c);
    ext_en[4] <= 1'b1;
    wr(ad(4), 8'h01);
    pad(4, 1'b0, 1'b0);
    check("gpio_in", {31'h0, gpio_in[4]}, 32'h0000_0000);
    wr(ad(4), 8'h03);
    pad(4, 1'b0, 1'b0);
    check("gpio_in_inv", {31'h0, gpio_in[4]}, 32'h0000_0001);
    // Pins 2.1 and 2.2: edge pulses only when the field selects them.
    for (int k = 0; k < 4; k++) begin
      ext_en[2 + k % 2] <= 1'b1;
      wr(ad(2 + k % 2), (k < 2) ? 8'h79 : 8'h05);
      repeat (3) @(posedge mclk_i);
      for (int t = 0; t < 2; t++) begin
        ext_val[2 + k % 2] <= ~ext_val[2 + k % 2];
        n = 0;
        repeat (8) begin
          @(posedge mclk_i);
          if (alt_out.edge_irq[k % 2] === 1'b1) n++;
        end
        check("edge_pulses", n, (k < 2) ? 1 : 0);
      end
      check("kbc_in", {31'h0, (k % 2) ? alt_out.kbc_port_bit2 :
            alt_out.kbc_port_bit6}, (k < 2) ? 1 : 0);
    end
    // Alternate inputs follow the pad only while routed.
    foreach (ext_val[p]) begin
      if (p == 0 || p == 1 || p == 5 || p == 8 || p == 9) begin
        ext_en[p] <= 1'b1;
        ext_val[p] <= 1'b0;
        wr(ad(p), 8'h05);
        pad(p, 1'b0, 1'b0);
        check("alt_in", {31'h0, alt_of(p)}, 0);
        wr(ad(p), 8'h79);
        pad(p, 1'b0, 1'b0);
        check("alt_idle", {31'h0, alt_of(p)}, 1);
      end
    end
    // Alternate outputs override the data register value.
    ext_en <= '0;
    gpio_out <= '1;
    alt_in <= '0;
    wr(ad(6), 8'h04);
    pad(6, 1'b1, 1'b0);
    wr(ad(7), 8'h04);
    pad(7, 1'b1, 1'b0);
    wr(ad(2), 8'h0c);
    pad(2, 1'b1, 1'b0);
    wr(ad(3), 8'h0c);
    pad(3, 1'b1, 1'b0);
    close_out();
  end
endmodule : gcb_pin_cfg_bank_tb
